/* include/clock_select_consts.svh */
// Constants for the system clock source selection block.
`ifndef CLOCK_SELECT_CONSTS_SVH
`define CLOCK_SELECT_CONSTS_SVH
// Register indices on the special function register port.
`define REG_INTERNAL_OSC_CONTROL 2'h0
`define REG_INTERNAL_OSC_TRIM    2'h1
`define REG_SYSTEM_CLOCK_SELECT  2'h2
`define REG_CLOCK_STATUS         2'h3
// Reset values.
`define INTERNAL_OSC_CONTROL_RST 8'hc0
`define SYSTEM_CLOCK_SELECT_RST  8'h00
`define INTERNAL_OSC_TRIM_RST    8'h00
// Field positions.
`define BIT_OSC_ENABLE  7
`define BIT_OSC_READY   6
`define SOURCE_INTERNAL 2'h0
`define SOURCE_EXTERNAL 2'h1
`define SOURCE_PLL      2'h2
// Internal oscillator settle count in core clock cycles after enable or change.
`define OSC_SETTLE_CYCLES 4'h4
`endif

/* include/clock_select_pkg.sv */
// Types for the system clock source selection block.
package clock_select_pkg;
   // Register port request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   // Selected clock source.
   typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_PLL, SRC_RSV} source_t;
endpackage

/* hw/system_clock_source_select.sv */
// System clock source selection, internal oscillator control and output divider.
`timescale 1ns/1ps
`include "clock_select_consts.svh"
module system_clock_source_select (
   input  wire logic                      core_clk,
   input  wire logic                      reset_n,
   input  wire clock_select_pkg::reg_req_t reg_req,
   output logic [7:0]                     reg_rdata_q,
   input  wire logic                      int_osc_tick,
   input  wire logic                      ext_osc_tick,
   input  wire logic                      pll_tick,
   input  wire logic                      ext_settled,
   input  wire logic                      pll_locked,
   output logic                           int_osc_run_q,
   output logic [7:0]                     internal_osc_trim_q,
   output logic [1:0]                     clock_source_q,
   output logic                           system_clock_q,
   output logic                           clock_output_q,
   output logic                           ext_peripheral_clock_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and synchronisers.
   logic       osc_enable_q, osc_enable_d;        // Internal oscillator enable.
   logic [1:0] osc_div_q, osc_div_d;              // Internal oscillator divide select.
   logic [7:0] trim_d;                            // Next trim value.
   logic [1:0] source_d;                          // Next source field.
   logic [1:0] out_div_q, out_div_d;              // Output divide field.
   logic [3:0] settle_q, settle_d;                // Settle counter.
   logic       ready_q, ready_d;                  // Oscillator ready flag.
   logic [7:0] rdata_d;                           // Next read data.
   logic [2:0] int_s1_q, int_s2_q;                // Two-stage sync of the three source levels.
   logic       int_s3_q;                          // Internal oscillator level one cycle later.
   logic [2:0] tick_s1_d;                         // Raw sampled ticks.
   logic       ext_ok_s1_q, ext_ok_q;             // Crystal valid synchroniser.
   logic       pll_ok_s1_q, pll_ok_q;             // PLL lock synchroniser.
   logic       rise;                              // Rising edge of the internal oscillator.
   logic [2:0] div_cnt_q, div_cnt_d;              // Internal oscillator divider.
   logic       int_div_q, int_div_d;              // Divided internal oscillator level.
   logic       sys_d, sys_edge;                   // Selected clock level and its rise.
   logic [2:0] out_cnt_q, out_cnt_d;              // Output divider counter.
   logic       clk_out_d;                         // Next output level.

   // Decode a two-bit divide code into a mask of divider bits to toggle.
   // The output divider passes its code inverted, so both dividers share one decode.
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      unique case (code)
         2'h0:       div_mask = 3'h3;
         2'h1:       div_mask = 3'h1;
         2'h2, 2'h3: div_mask = 3'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, settle tracking and read mux.
   always_comb begin
      osc_enable_d = osc_enable_q;
      osc_div_d    = osc_div_q;
      trim_d       = internal_osc_trim_q;
      source_d     = clock_source_q;
      out_div_d    = out_div_q;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `REG_INTERNAL_OSC_CONTROL: begin
               // Enable and divide land together; ready bit is not writable.
               osc_enable_d = reg_req.wdata[`BIT_OSC_ENABLE];
               osc_div_d    = reg_req.wdata[1:0];
            end
            `REG_INTERNAL_OSC_TRIM: begin
               trim_d = reg_req.wdata;
            end
            `REG_SYSTEM_CLOCK_SELECT: begin
               source_d  = reg_req.wdata[1:0];
               out_div_d = reg_req.wdata[5:4];
            end
            default: begin
               // Status is read only.
            end
         endcase
      end
      // Ready drops on disable or any frequency change, then returns after settling.
      if (!osc_enable_d || (osc_div_d != osc_div_q) || (trim_d != internal_osc_trim_q)) begin
         settle_d = `OSC_SETTLE_CYCLES;
         ready_d  = 1'b0;
      end else if (settle_q != 4'h0) begin
         settle_d = settle_q - 4'h1;
         ready_d  = 1'b0;
      end else begin
         settle_d = 4'h0;
         ready_d  = osc_enable_q;
      end
      // Reserved bits read zero.
      unique case (reg_req.addr)
         `REG_INTERNAL_OSC_CONTROL: rdata_d = {osc_enable_q, ready_q, 4'h0, osc_div_q};
         `REG_INTERNAL_OSC_TRIM:    rdata_d = internal_osc_trim_q;
         `REG_SYSTEM_CLOCK_SELECT:  rdata_d = {2'h0, out_div_q, 2'h0, clock_source_q};
         default:                   rdata_d = {6'h0, pll_ok_q, ext_ok_q};
      endcase
      if (!reg_req.rd) begin
         rdata_d = reg_rdata_q;
      end
   end

   // Register state; reset returns the internal oscillator as source.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_enable_q        <= 1'b1;
         ready_q             <= 1'b1;
         osc_div_q           <= 2'h0;
         internal_osc_trim_q <= `INTERNAL_OSC_TRIM_RST;
         clock_source_q      <= `SOURCE_INTERNAL;
         out_div_q           <= 2'h0;
         settle_q            <= 4'h0;
         reg_rdata_q         <= 8'h00;
      end else begin
         osc_enable_q        <= osc_enable_d;
         ready_q             <= ready_d;
         osc_div_q           <= osc_div_d;
         internal_osc_trim_q <= trim_d;
         clock_source_q      <= source_d;
         out_div_q           <= out_div_d;
         settle_q            <= settle_d;
         reg_rdata_q         <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock path: sampled ticks, dividers and source mux.
   always_comb begin
      tick_s1_d = {pll_tick, ext_osc_tick, int_osc_tick};
      rise      = int_s2_q[0] & ~int_s3_q;
      // Internal oscillator divide by 8, 4, 2 or 1.
      div_cnt_d = div_cnt_q;
      int_div_d = int_div_q;
      if (osc_div_q == 2'h3) begin
         int_div_d = int_s2_q[0];
      end else if (rise) begin
         if ((div_cnt_q & div_mask(osc_div_q)) == div_mask(osc_div_q)) begin
            div_cnt_d = 3'h0;
            int_div_d = ~int_div_q;
         end else begin
            div_cnt_d = div_cnt_q + 3'h1;
         end
      end
      // Reserved code holds the clock low.
      unique case (clock_source_q)
         `SOURCE_INTERNAL: sys_d = int_div_q & osc_enable_q;
         // The external source is used as soon as selected; no start-up wait is imposed.
         `SOURCE_EXTERNAL: sys_d = int_s2_q[1];
         `SOURCE_PLL:      sys_d = int_s2_q[2];
         default:          sys_d = 1'b0;
      endcase
      sys_edge  = sys_d & ~system_clock_q;
      // Output divider: /1 follows the clock, otherwise toggles on its rises.
      out_cnt_d = out_cnt_q;
      clk_out_d = clock_output_q;
      if (out_div_q == 2'h0) begin
         clk_out_d = sys_d;
      end else if (sys_edge) begin
         // Code 01 toggles on every rise, 10 on every second and 11 on every fourth.
         if ((out_cnt_q & div_mask(~out_div_q)) == div_mask(~out_div_q)) begin
            out_cnt_d = 3'h0;
            clk_out_d = ~clock_output_q;
         end else begin
            out_cnt_d = out_cnt_q + 3'h1;
         end
      end
   end

   // Clock path registers; external clock stays out for timers in every mode.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_s1_q               <= 3'h0;
         int_s2_q               <= 3'h0;
         int_s3_q               <= 1'b0;
         ext_ok_s1_q            <= 1'b0;
         ext_ok_q               <= 1'b0;
         pll_ok_s1_q            <= 1'b0;
         pll_ok_q               <= 1'b0;
         div_cnt_q              <= 3'h0;
         int_div_q              <= 1'b0;
         system_clock_q         <= 1'b0;
         out_cnt_q              <= 3'h0;
         clock_output_q         <= 1'b0;
         ext_peripheral_clock_q <= 1'b0;
         int_osc_run_q          <= 1'b1;
      end else begin
         int_s1_q               <= tick_s1_d;
         int_s2_q               <= int_s1_q;
         // Only the second stage reads the first; edge history reads the synchronised level.
         int_s3_q               <= int_s2_q[0];
         ext_ok_s1_q            <= ext_settled;
         ext_ok_q               <= ext_ok_s1_q;
         pll_ok_s1_q            <= pll_locked;
         pll_ok_q               <= pll_ok_s1_q;
         div_cnt_q              <= div_cnt_d;
         int_div_q              <= int_div_d;
         system_clock_q         <= sys_d;
         out_cnt_q              <= out_cnt_d;
         clock_output_q         <= clk_out_d;
         ext_peripheral_clock_q <= int_s2_q[1];
         int_osc_run_q          <= osc_enable_d;
      end
   end

endmodule

/* verif/system_clock_source_select_props.sv */
// Port-level checks for the system clock source selection block.
`timescale 1ns/1ps
module system_clock_source_select_props (
   input wire logic                       core_clk,
   input wire logic                       reset_n,
   input wire clock_select_pkg::reg_req_t reg_req,
   input wire logic [7:0]                 reg_rdata_q,
   input wire logic                       ext_settled,
   input wire logic                       pll_locked,
   input wire logic                       int_osc_run_q,
   input wire logic [7:0]                 internal_osc_trim_q,
   input wire logic [1:0]                 clock_source_q,
   input wire logic                       system_clock_q
);
   // Every check runs on the core clock and rests while reset is low.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_rst_src; $rose(reset_n) |-> clock_source_q == 2'h0; endproperty
   a_rst_src: assert property (p_rst_src) else $error("source not internal");
   property p_trim; reg_req.wr && reg_req.addr == 2'h1 |=> internal_osc_trim_q == $past(reg_req.wdata); endproperty
   a_trim: assert property (p_trim) else $error("trim not taken");
   property p_en; reg_req.wr && reg_req.addr == 2'h0 |=> int_osc_run_q == $past(reg_req.wdata[7]); endproperty
   a_en: assert property (p_en) else $error("enable not taken");
   property p_src; reg_req.wr && reg_req.addr == 2'h2 |=> clock_source_q == $past(reg_req.wdata[1:0]); endproperty
   a_src: assert property (p_src) else $error("source not taken");
   property p_rsv; (clock_source_q == 2'h3) [*3] |-> !system_clock_q; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved source clocks");
   property p_xtal; ext_settled [*4] ##0 (reg_req.rd && reg_req.addr == 2'h3) |=> reg_rdata_q[0]; endproperty
   a_xtal: assert property (p_xtal) else $error("crystal flag low");
   property p_lock; pll_locked [*4] ##0 (reg_req.rd && reg_req.addr == 2'h3) |=> reg_rdata_q[1]; endproperty
   a_lock: assert property (p_lock) else $error("lock flag low");
   property p_rdy;
      (reg_req.wr && reg_req.addr == 2'h0 && !reg_req.wdata[7]) ##2 (reg_req.rd && reg_req.addr == 2'h0)
      |=> !reg_rdata_q[6];
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready while disabled");
endmodule
bind system_clock_source_select system_clock_source_select_props u_props (.core_clk(core_clk), .reset_n(reset_n),
   .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .ext_settled(ext_settled), .pll_locked(pll_locked),
   .int_osc_run_q(int_osc_run_q), .internal_osc_trim_q(internal_osc_trim_q), .clock_source_q(clock_source_q),
   .system_clock_q(system_clock_q));

/* verif/system_clock_source_select_tb_top.sv */
// Self-checking bench for the system clock source selection block.
`timescale 1ns/1ps
module system_clock_source_select_tb_top;
   logic                       core_clk = 1'b0;
   logic                       reset_n = 1'b0;
   clock_select_pkg::reg_req_t reg_req = '0;
   logic                       int_osc_tick = 1'b0, ext_osc_tick = 1'b0, pll_tick = 1'b0;
   logic                       ext_settled = 1'b0, pll_locked = 1'b0;
   logic [7:0]                 reg_rdata_q, internal_osc_trim_q;
   logic [1:0]                 clock_source_q;
   logic                       int_osc_run_q, system_clock_q, clock_output_q, ext_peripheral_clock_q;
   int                         cyc = 0, ns, no, ne, errors = 0, n_compared = 0;
   system_clock_source_select dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q), .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick), .pll_tick(pll_tick),
      .ext_settled(ext_settled), .pll_locked(pll_locked), .int_osc_run_q(int_osc_run_q),
      .internal_osc_trim_q(internal_osc_trim_q), .clock_source_q(clock_source_q), .system_clock_q(system_clock_q),
      .clock_output_q(clock_output_q), .ext_peripheral_clock_q(ext_peripheral_clock_q));
   initial forever #12.5 core_clk = ~core_clk;
   // Source clocks with periods of 4, 6 and 10 core cycles, slow enough to be sampled.
   // The external source runs from the start, as if already set up for its type and range.
   always @(posedge core_clk) begin
      #2 cyc = cyc + 1;
      int_osc_tick = cyc % 4 < 2;
      ext_osc_tick = cyc % 6 < 3;
      pll_tick = cyc % 10 < 5;
   end
   always @(posedge system_clock_q) ns++;
   always @(posedge clock_output_q) no++;
   always @(posedge ext_peripheral_clock_q) ne++;
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Rise counts may be off by one at the window edges.
   task automatic chkn(string nm, int exp, int got);
      chk(nm, 8'(exp), (got >= exp - 1 && got <= exp + 1) ? 8'(exp) : 8'(got));
   endtask
   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge core_clk) #2 reg_req = '{1'b1, 1'b0, a, d};
      @(posedge core_clk) #2 reg_req = '0;
   endtask
   task automatic rd(logic [1:0] a, logic [7:0] exp, string nm);
      @(posedge core_clk) #2 reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) #2 reg_req = '0;
      chk(nm, exp, reg_rdata_q);
   endtask
   // Writes a setting, lets it settle, then counts clock rises over 256 cycles.
   task automatic meas(logic [1:0] a, logic [7:0] d);
      wr(a, d);
      repeat (16) @(posedge core_clk);
      #2 {ns, no, ne} = '0;
      repeat (256) @(posedge core_clk);
      #2;
   endtask
   task automatic t_reset;
      chk("source port", 8'h00, {6'h00, clock_source_q});
      rd(2'h0, 8'hc0, "control reset");
      rd(2'h2, 8'h00, "select reset");
   endtask
   task automatic t_trim;
      wr(2'h1, 8'ha5);
      rd(2'h1, 8'ha5, "trim read");
      chk("trim port", 8'ha5, internal_osc_trim_q);
   endtask
   task automatic t_divide;
      for (int k = 0; k < 4; k++) begin
         meas(2'h0, {6'h20, k[1:0]});
         chkn("system rises", 8 << k, ns);
      end
      for (int k = 0; k < 4; k++) begin
         meas(2'h2, {2'h0, k[1:0], 4'h0});
         chkn("output rises", 64 >> k, no);
      end
   endtask
   task automatic t_source;
      // Both sources settle, and software sees so, before any switch to them.
      @(posedge core_clk) #2 {ext_settled, pll_locked} = 2'b11;
      repeat (4) @(posedge core_clk);
      rd(2'h3, 8'h03, "flags before switch");
      meas(2'h2, 8'h01);
      chkn("external rises", 42, ns);
      meas(2'h2, 8'h02);
      chkn("pll rises", 25, ns);
      chkn("peripheral rises", 42, ne);
      meas(2'h2, 8'h03);
      chkn("reserved rises", 0, ns);
      wr(2'h2, 8'hff);
      rd(2'h2, 8'h33, "select bits");
      // A reset in mid-run must return the internal oscillator as source.
      @(posedge core_clk) #2 reset_n = 1'b0;
      @(posedge core_clk) #2 reset_n = 1'b1;
      chk("source after reset", 8'h00, {6'h00, clock_source_q});
      rd(2'h2, 8'h00, "select after reset");
      @(posedge core_clk) #2 {ext_settled, pll_locked} = 2'b00;
   endtask
   task automatic t_ready;
      wr(2'h0, 8'h7f);
      rd(2'h0, 8'h03, "disabled");
      chk("oscillator run", 8'h00, {7'h00, int_osc_run_q});
      wr(2'h0, 8'h83);
      rd(2'h0, 8'h83, "starting");
      chk("oscillator run", 8'h01, {7'h00, int_osc_run_q});
      repeat (8) @(posedge core_clk);
      rd(2'h0, 8'hc3, "settled");
   endtask
   task automatic t_flags;
      // The external oscillator counts as enabled here; polling waits 1 ms, 40000 cycles.
      @(posedge core_clk) #2 ext_settled = 1'b1;
      repeat (40000) @(posedge core_clk);
      rd(2'h3, 8'h01, "crystal flag");
      @(posedge core_clk) #2 {ext_settled, pll_locked} = 2'b01;
      repeat (4) @(posedge core_clk);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h02, "lock flag");
   endtask
   task automatic report_and_stop;
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      #2 reset_n = 1'b1;
      t_reset;
      t_trim;
      t_divide;
      t_source;
      t_ready;
      t_flags;
      report_and_stop;
   end
   // About 80000 cycles, nearly twice the expected run.
   initial begin
      #2000000 errors++;
      report_and_stop;
   end
endmodule
